// ===== hdl/isp_flash_ctrl.sv
/*
 * In-system flash programming controller: APB register file, control
 * register unlock, idle-time flash operation sequencer, bank switch on
 * wake-up and software reset request.
 * Assumes cpu_idle and the flash array handshake run on pclk.
 */
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module isp_flash_ctrl
	import isp_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int LD_ADDR_W = isp_pkg::LOAD_ADDR_W
)
(
	// Clock and reset
	input logic pclk,
	input logic presetn,
	// APB slave
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [ADDR_W-1:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// CPU side
	input logic cpu_idle,
	output logic fetch_loader,
	output logic pc_clear,
	output logic cpu_reset_req,
	// Flash array
	output logic fl_req,
	output logic fl_bank,
	output logic fl_oe,
	output logic fl_ce,
	output logic [3:0] fl_op,
	output logic [isp_pkg::MAIN_ADDR_W-1:0] fl_addr,
	output logic [7:0] fl_wdata,
	input logic [7:0] fl_rdata,
	input logic fl_done
);

	// ----------------------------------------------------------------
	// Parameter checks
	// ----------------------------------------------------------------
	if (ADDR_W < 10 || LD_ADDR_W < 1 || LD_ADDR_W > MAIN_ADDR_W)
	begin : g_bad_param
		$error("isp_flash_ctrl: unsupported address widths");
	end

	localparam logic [MAIN_ADDR_W-1:0] LD_MASK =
		MAIN_ADDR_W'((32'd1 << LD_ADDR_W) - 32'd1);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] idx);
		return a == ADDR_W'({idx, 2'b00});
	endfunction : hit

	// Only the three documented combinations start the array
	function automatic logic cmd_ok(input logic [7:0] c);
		logic ce_n;
		logic oe;
		ce_n = c[CMD_CE_BIT];
		oe = c[CMD_OE_BIT];
		return !ce_n && ((c[3:0] == OP_READ && !oe) ||
			(c[3:0] == OP_PROG && oe) ||
			(c[3:0] == OP_ERASE && oe));
	endfunction : cmd_ok

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [7:0] ctrl_r;
	logic [7:0] cmd_r;
	logic [7:0] addr_hi_r;
	logic [7:0] addr_lo_r;
	logic [7:0] data_r;
	logic loader_r;
	logic pc_clear_r;
	logic swreset_r;
	logic idle_q_r;
	logic fl_req_r;
	logic fl_bank_r;
	logic fl_oe_r;
	logic fl_ce_r;
	logic [3:0] fl_op_r;
	logic [MAIN_ADDR_W-1:0] fl_addr_r;
	logic [7:0] fl_wdata_r;
	isp_state_t state_r;
	isp_state_t state_nxt;
	logic ctrl_wr_en;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	// Writes land in the access cycle, when pready is already high
	wire setup = psel & ~penable;
	wire wr = psel & penable & pready_r & pwrite;
	wire sel_ctrl = hit(paddr, IDX_CTRL);
	wire sel_unlock = hit(paddr, IDX_UNLOCK);
	wire sel_lo = hit(paddr, IDX_ADDR_LO);
	wire sel_hi = hit(paddr, IDX_ADDR_HI);
	wire sel_data = hit(paddr, IDX_DATA);
	wire sel_cmd = hit(paddr, IDX_CMD);
	wire mapped = sel_ctrl | sel_unlock | sel_lo | sel_hi | sel_data | sel_cmd;
	wire wr_ctrl = wr & sel_ctrl & ctrl_wr_en;
	wire [7:0] ctrl_view = (ctrl_r & CTRL_WMASK) | CTRL_ONES |
		(8'(loader_r) << CTRL_LDR_BIT);
	// Unlock register reads back zero so keys cannot be snooped
	wire [7:0] rd_byte = sel_ctrl ? ctrl_view :
		sel_lo ? addr_lo_r :
		sel_hi ? addr_hi_r :
		sel_data ? data_r :
		sel_cmd ? cmd_r : 8'h00;

	// ----------------------------------------------------------------
	// Sequencer decode
	// ----------------------------------------------------------------
	wire idle_rise = cpu_idle & ~idle_q_r;
	wire idle_fall = ~cpu_idle & idle_q_r;
	wire prog_en = ctrl_r[CTRL_PROG_BIT];
	wire swr_all = (ctrl_r & CTRL_SWR_ALL) == CTRL_SWR_ALL;
	wire start_op = (state_r == ISP_RUN) & idle_rise & prog_en &
		cmd_ok(cmd_r);
	wire op_end = (state_r == ISP_BUSY) & fl_done;
	wire [MAIN_ADDR_W-1:0] tgt_addr = {addr_hi_r, addr_lo_r};
	wire ld_bank = cmd_r[CMD_BANK_BIT];

	// ----------------------------------------------------------------
	// Key gate
	// ----------------------------------------------------------------
	isp_unlock u_unlock (
		.pclk(pclk),
		.presetn(presetn),
		.key_wr(wr & sel_unlock),
		.key_data(pwdata[7:0]),
		.ctrl_wr_en(ctrl_wr_en)
	);

	// ----------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------
	// Answer registered in setup so every output comes from a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end
		else
		begin
			prdata_r <= setup ? {24'h00_0000, rd_byte} : prdata_r;
			pready_r <= setup;
			pslverr_r <= setup & ~mapped;
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	// A finished read wins over a same-cycle data write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_r <= CMD_RST;
			addr_hi_r <= BYTE_RST;
			addr_lo_r <= BYTE_RST;
			data_r <= BYTE_RST;
		end
		else
		begin
			if (wr & sel_cmd)
				cmd_r <= pwdata[7:0] & CMD_WMASK;
			if (wr & sel_hi)
				addr_hi_r <= pwdata[7:0];
			if (wr & sel_lo)
				addr_lo_r <= pwdata[7:0];
			if (op_end && fl_op_r == OP_READ)
				data_r <= fl_rdata;
			else if (wr & sel_data)
				data_r <= pwdata[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Control register and bank state
	// ----------------------------------------------------------------
	// Reset and bank switch wait for wake-up, so the CPU has left idle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= CTRL_RST;
			loader_r <= 1'b0;
			pc_clear_r <= 1'b0;
			swreset_r <= 1'b0;
			idle_q_r <= 1'b0;
		end
		else
		begin
			idle_q_r <= cpu_idle;
			pc_clear_r <= 1'b0;
			swreset_r <= 1'b0;
			if (idle_fall && swr_all)
			begin
				swreset_r <= 1'b1;
				loader_r <= 1'b0;
				ctrl_r <= CTRL_RST;
			end
			else
			begin
				if (idle_fall && prog_en && !loader_r)
				begin
					loader_r <= 1'b1;
					pc_clear_r <= 1'b1;
				end
				if (wr_ctrl)
					ctrl_r <= pwdata[7:0] & CTRL_WMASK;
			end
		end
	end

	// ----------------------------------------------------------------
	// Operation sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ISP_RUN:
				if (start_op)
					state_nxt = ISP_BUSY;
			ISP_BUSY:
				if (fl_done)
					state_nxt = cpu_idle ? ISP_HOLD : ISP_RUN;
			ISP_HOLD:
				if (!cpu_idle)
					state_nxt = ISP_RUN;
			default:
				state_nxt = ISP_RUN;
		endcase
	end

	// Array signals held from start to done; later writes cannot disturb
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= ISP_RUN;
			fl_req_r <= 1'b0;
			fl_bank_r <= 1'b0;
			fl_oe_r <= 1'b0;
			fl_ce_r <= 1'b1;
			fl_op_r <= OP_READ;
			fl_addr_r <= '0;
			fl_wdata_r <= BYTE_RST;
		end
		else
		begin
			state_r <= state_nxt;
			if (start_op)
			begin
				fl_req_r <= 1'b1;
				fl_bank_r <= ld_bank;
				fl_oe_r <= cmd_r[CMD_OE_BIT];
				fl_ce_r <= cmd_r[CMD_CE_BIT];
				fl_op_r <= cmd_r[3:0];
				fl_addr_r <= ld_bank ? (tgt_addr & LD_MASK) :
					tgt_addr;
				fl_wdata_r <= data_r;
			end
			else if (op_end)
			begin
				fl_req_r <= 1'b0;
				fl_ce_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign fetch_loader = loader_r;
	assign pc_clear = pc_clear_r;
	assign cpu_reset_req = swreset_r;
	assign fl_req = fl_req_r;
	assign fl_bank = fl_bank_r;
	assign fl_oe = fl_oe_r;
	assign fl_ce = fl_ce_r;
	assign fl_op = fl_op_r;
	assign fl_addr = fl_addr_r;
	assign fl_wdata = fl_wdata_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_start_on_idle: assert property (
		start_op |=> fl_req && fl_op == $past(cmd_r[3:0]))
		else $error("operation not started on idle entry");
	a_op_in_idle: assert property (
		$rose(fl_req) |-> cpu_idle && $past(prog_en))
		else $error("flash operation outside idle");
	a_addr_form: assert property (
		$rose(fl_req) && !fl_bank |-> fl_addr ==
		{$past(addr_hi_r), $past(addr_lo_r)})
		else $error("target address wrongly formed");
	a_loader_range: assert property (
		fl_req && fl_bank |-> (fl_addr & ~LD_MASK) == '0)
		else $error("loader bank address out of range");
	a_read_back: assert property (
		op_end && fl_op == OP_READ |=> data_r == $past(fl_rdata))
		else $error("read data not returned");
	a_erase_code: assert property (
		fl_req && fl_op == OP_ERASE |-> fl_oe && !fl_ce)
		else $error("erase with wrong enables");
	a_prog_code: assert property (
		fl_req && fl_op == OP_PROG |-> fl_oe && !fl_ce)
		else $error("program with wrong enables");
	a_bank_switch: assert property (
		idle_fall && prog_en && !loader_r && !swr_all
		|=> fetch_loader && pc_clear ##1 !pc_clear)
		else $error("no loader switch on wake-up");
	a_sw_reset: assert property (
		idle_fall && swr_all |=> cpu_reset_req && !fetch_loader)
		else $error("software reset not raised");
	a_apb_ready: assert property (
		setup |=> pready ##1 !pready || setup)
		else $error("bus answer late");

	c_read_op: cover property (op_end && fl_op == OP_READ);
	c_prog_op: cover property (op_end && fl_op == OP_PROG);
	c_erase_op: cover property (op_end && fl_op == OP_ERASE);
	c_sw_reset: cover property (cpu_reset_req);

endmodule : isp_flash_ctrl

// ===== inc/isp_pkg.sv
/*
 * Shared constants for the in-system flash programming controller:
 * register indices, field positions, unlock keys, operation codes and
 * the sequencer state type.
 * Assumes a 32-bit APB bus where byte address = 4 * register index.
 */
package isp_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CTRL = 8'hBF;
	localparam logic [7:0] IDX_UNLOCK = 8'hC0;
	localparam logic [7:0] IDX_ADDR_LO = 8'hC4;
	localparam logic [7:0] IDX_ADDR_HI = 8'hC5;
	localparam logic [7:0] IDX_DATA = 8'hC6;
	localparam logic [7:0] IDX_CMD = 8'hC7;

	// ----------------------------------------------------------------
	// Unlock keys
	// ----------------------------------------------------------------
	localparam logic [7:0] UNLOCK_KEY1 = 8'h87;
	localparam logic [7:0] UNLOCK_KEY2 = 8'h59;

	// ----------------------------------------------------------------
	// Programming control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_PROG_BIT = 0;
	localparam int CTRL_BOOT_BIT = 1;
	localparam int CTRL_AUX_BIT = 4;
	localparam int CTRL_LDR_BIT = 5;
	localparam int CTRL_SWR_BIT = 7;
	localparam logic [7:0] CTRL_WMASK = 8'h93;
	localparam logic [7:0] CTRL_ONES = 8'h08;
	localparam logic [7:0] CTRL_SWR_ALL = 8'h83;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// ----------------------------------------------------------------
	// Flash command register fields
	// ----------------------------------------------------------------
	localparam int CMD_BANK_BIT = 6;
	localparam int CMD_OE_BIT = 5;
	localparam int CMD_CE_BIT = 4;
	localparam logic [7:0] CMD_WMASK = 8'h7F;
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] OP_READ = 4'h0;
	localparam logic [3:0] OP_PROG = 4'h1;
	localparam logic [3:0] OP_ERASE = 4'h2;

	// ----------------------------------------------------------------
	// Bank sizes as address widths
	// ----------------------------------------------------------------
	localparam int MAIN_ADDR_W = 16;
	localparam int LOAD_ADDR_W = 12;

	// Operation sequencer states
	typedef enum logic [1:0] {ISP_RUN, ISP_BUSY, ISP_HOLD} isp_state_t;

endpackage : isp_pkg

// ===== hdl/isp_unlock.sv
/*
 * Write-permission gate for the programming control register.
 * Assumes key_wr is a one-cycle pulse per accepted bus write.
 */
`timescale 1ns/1ps
module isp_unlock
	import isp_pkg::*;
(
	// Clock and reset
	input logic pclk,
	input logic presetn,
	// Key writes
	input logic key_wr,
	input logic [7:0] key_data,
	// Permission
	output logic ctrl_wr_en
);

	logic armed_r;
	logic en_r;

	// ----------------------------------------------------------------
	// Key sequence
	// ----------------------------------------------------------------
	// The second key only counts right after the first one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			armed_r <= 1'b0;
			en_r <= 1'b0;
		end
		else if (key_wr)
		begin
			armed_r <= (key_data == UNLOCK_KEY1);
			if (key_data == UNLOCK_KEY2 && armed_r)
				en_r <= 1'b1;
			else if (key_data != UNLOCK_KEY1 && key_data != UNLOCK_KEY2)
				en_r <= 1'b0;
		end
	end

	assign ctrl_wr_en = en_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_unlock_arm: assert property (
		key_wr && key_data == UNLOCK_KEY1 |=> armed_r)
		else $error("first key did not arm");
	a_unlock_pair: assert property (
		key_wr && key_data == UNLOCK_KEY2 && armed_r |=> ctrl_wr_en)
		else $error("key pair did not unlock");
	a_unlock_only: assert property (
		$rose(ctrl_wr_en) |-> $past(key_wr) && $past(armed_r) &&
		$past(key_data) == UNLOCK_KEY2)
		else $error("register opened without key pair");
	a_unlock_close: assert property (
		key_wr && key_data != UNLOCK_KEY1 && key_data != UNLOCK_KEY2
		|=> !ctrl_wr_en)
		else $error("bad key left register writable");

endmodule : isp_unlock

// ===== dv/isp_flash_model.sv
/*
 * Behavioural model of the on-chip flash banks behind the sequencer.
 * Assumes the sequencer holds its fl_* request steady until fl_done.
 */
`timescale 1ns/1ps
module isp_flash_model
#(
	parameter int DELAY = 4
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Request from the sequencer
	input wire logic fl_req,
	input wire logic fl_bank,
	input wire logic fl_oe,
	input wire logic fl_ce,
	input wire logic [3:0] fl_op,
	input wire logic [15:0] fl_addr,
	input wire logic [7:0] fl_wdata,
	// Answer
	output logic [7:0] fl_rdata,
	output logic fl_done
);
	// ----------------------------------------------------------------
	// Storage: 64K main bank and 4K loader bank
	// ----------------------------------------------------------------
	logic [7:0] main_mem [0:65535];
	logic [7:0] ldr_mem [0:4095];
	int cnt;
	logic served;

	// Both banks start erased
	initial
	begin
		for (int i = 0; i < 65536; i++) main_mem[i] = 8'hFF;
		for (int i = 0; i < 4096; i++) ldr_mem[i] = 8'hFF;
	end

	// One answer per request; the byte lane wanders when not answering
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt <= 0;
			served <= 1'b0;
			fl_done <= 1'b0;
			fl_rdata <= 8'h00;
		end
		else
		begin
			fl_done <= 1'b0;
			fl_rdata <= ~fl_rdata;
			if (!fl_req)
			begin
				cnt <= 0;
				served <= 1'b0;
			end
			else if (!served && !fl_ce && cnt < DELAY)
				cnt <= cnt + 1;
			else if (!served && !fl_ce)
			begin
				served <= 1'b1;
				fl_done <= 1'b1;
				// Real flash programming only clears bits
				if (fl_op == 4'h2 && fl_oe)
					for (int i = 0; i < 65536; i++)
						if (fl_bank) ldr_mem[i % 4096] = 8'hFF;
						else main_mem[i] = 8'hFF;
				else if (fl_op == 4'h1 && fl_oe && fl_bank)
					ldr_mem[fl_addr[11:0]] = ldr_mem[fl_addr[11:0]] & fl_wdata;
				else if (fl_op == 4'h1 && fl_oe)
					main_mem[fl_addr] = main_mem[fl_addr] & fl_wdata;
				else if (fl_op == 4'h0)
					fl_rdata <= fl_bank ? ldr_mem[fl_addr[11:0]] :
						main_mem[fl_addr];
			end
		end
	end
endmodule : isp_flash_model

// ===== dv/tb_top.sv
/*
 * Self-checking bench for the flash programming controller.
 * Assumes APB zero-wait slave and a flash model on the array side.
 */
`timescale 1ns/1ps
module tb_top;
	import isp_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, cpu_idle;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_data;
	logic pready, pslverr, rd_err, fetch_loader, pc_clear, cpu_reset_req;
	logic fl_req, fl_bank, fl_oe, fl_ce, fl_done, req_seen;
	logic [3:0] fl_op;
	logic [15:0] fl_addr, snap_addr;
	logic [7:0] fl_wdata, fl_rdata, snap_wd;
	logic [6:0] snap;
	int failures, check_count, pc_n, rst_n;

	isp_flash_ctrl isp_flash_ctrl_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_idle(cpu_idle),
		.fetch_loader(fetch_loader), .pc_clear(pc_clear),
		.cpu_reset_req(cpu_reset_req), .fl_req(fl_req), .fl_bank(fl_bank),
		.fl_oe(fl_oe), .fl_ce(fl_ce), .fl_op(fl_op), .fl_addr(fl_addr),
		.fl_wdata(fl_wdata), .fl_rdata(fl_rdata), .fl_done(fl_done));
	isp_flash_model isp_flash_model_i (.pclk(pclk), .presetn(presetn),
		.fl_req(fl_req), .fl_bank(fl_bank), .fl_oe(fl_oe), .fl_ce(fl_ce),
		.fl_op(fl_op), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
		.fl_rdata(fl_rdata), .fl_done(fl_done));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, string what);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// One APB transfer; waits for pready rather than assuming a latency
	task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd_data, {24'h000000, exp}, "read data");
	endtask : rd

	// Idle period: snapshot the request, then wake and count pulses
	task do_idle();
		@(posedge pclk);
		cpu_idle <= 1'b1;
		req_seen = 1'b0;
		// Software keeps idle long enough for the slowest operation
		for (int i = 0; i < 30; i++)
		begin
			@(posedge pclk);
			if (fl_req === 1'b1 && !req_seen)
			begin
				req_seen = 1'b1;
				snap = {fl_bank, fl_oe, fl_ce, fl_op};
				snap_addr = fl_addr;
				snap_wd = fl_wdata;
			end
		end
		chk(fl_req, 1'b0, "op done before wake");
		chk(fl_ce, 1'b1, "chip enable idle");
		cpu_idle <= 1'b0;
		pc_n = 0;
		rst_n = 0;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge pclk);
			pc_n += (pc_clear === 1'b1);
			rst_n += (cpu_reset_req === 1'b1);
		end
	endtask : do_idle

	task test_done();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset();
		chk(fetch_loader, 1'b0, "boots main bank");
		rd(IDX_CTRL, 8'h08);
		chk(rd_err, 1'b0, "mapped read no error");
		rd(IDX_CMD, 8'h00);
		rd(8'h10, 8'h00);
		chk(rd_err, 1'b1, "unmapped error");
		$display("test reset done");
	endtask : t_reset

	task t_lock();
		apb(1'b1, IDX_CTRL, 8'h01);
		rd(IDX_CTRL, 8'h08);
		apb(1'b1, IDX_UNLOCK, UNLOCK_KEY2);
		apb(1'b1, IDX_CTRL, 8'h01);
		rd(IDX_CTRL, 8'h08);
		apb(1'b1, IDX_UNLOCK, UNLOCK_KEY1);
		apb(1'b1, IDX_UNLOCK, UNLOCK_KEY2);
		apb(1'b1, IDX_CTRL, 8'h01);
		rd(IDX_CTRL, 8'h09);
		apb(1'b1, IDX_UNLOCK, 8'h00);
		apb(1'b1, IDX_CTRL, 8'h00);
		rd(IDX_CTRL, 8'h09);
		$display("test lock done");
	endtask : t_lock

	task t_prog();
		apb(1'b1, IDX_ADDR_HI, 8'hA5);
		apb(1'b1, IDX_ADDR_LO, 8'h3C);
		apb(1'b1, IDX_DATA, 8'h5A);
		apb(1'b1, IDX_CMD, 8'h21);
		chk(fl_req, 1'b0, "no op while running");
		do_idle();
		chk(req_seen, 1'b1, "program started");
		chk(snap, 7'h21, "program fields");
		chk(snap_addr, 16'hA53C, "program address");
		chk(snap_wd, 8'h5A, "program data");
		chk(pc_n, 1, "pc clear pulse");
		chk(fetch_loader, 1'b1, "runs loader");
		rd(IDX_CTRL, 8'h29);
		apb(1'b1, IDX_DATA, 8'h00);
		apb(1'b1, IDX_CMD, 8'h00);
		do_idle();
		chk(snap, 7'h00, "read fields");
		chk(pc_n, 0, "no second switch");
		rd(IDX_DATA, 8'h5A);
		$display("test program done");
	endtask : t_prog

	task t_loader();
		apb(1'b1, IDX_CMD, 8'hE2);
		rd(IDX_CMD, 8'h62);
		do_idle();
		chk(snap, 7'h62, "erase loader fields");
		apb(1'b1, IDX_ADDR_HI, 8'h12);
		apb(1'b1, IDX_ADDR_LO, 8'h34);
		apb(1'b1, IDX_DATA, 8'hC3);
		apb(1'b1, IDX_CMD, 8'h61);
		do_idle();
		chk(snap_addr, 16'h0234, "loader address");
		// Clear the data byte so only the read itself can restore it
		apb(1'b1, IDX_DATA, 8'h00);
		apb(1'b1, IDX_CMD, 8'h40);
		do_idle();
		rd(IDX_DATA, 8'hC3);
		apb(1'b1, IDX_CMD, 8'h31);
		do_idle();
		chk(req_seen, 1'b0, "chip disabled");
		apb(1'b1, IDX_CMD, 8'h01);
		do_idle();
		chk(req_seen, 1'b0, "program without oe");
		$display("test loader done");
	endtask : t_loader

	task t_swr();
		apb(1'b1, IDX_UNLOCK, UNLOCK_KEY1);
		apb(1'b1, IDX_UNLOCK, UNLOCK_KEY2);
		apb(1'b1, IDX_CTRL, CTRL_SWR_ALL);
		rd(IDX_CTRL, 8'hAB);
		do_idle();
		chk(rst_n, 1, "software reset pulse");
		chk(fetch_loader, 1'b0, "back to main");
		rd(IDX_CTRL, 8'h08);
		// Programming bit now clear: a valid command must not start
		apb(1'b1, IDX_CMD, 8'h00);
		do_idle();
		chk(req_seen, 1'b0, "op without prog bit");
		chk(pc_n, 0, "no switch without prog bit");
		chk(fetch_loader, 1'b0, "stays in main bank");
		$display("test software reset done");
	endtask : t_swr

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, cpu_idle} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		failures = 0;
		check_count = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_lock();
		t_prog();
		t_loader();
		t_swr();
		test_done();
	end

	// Whole run needs well under 2000 cycles
	initial
	begin
		repeat (20000) @(posedge pclk);
		failures++;
		test_done();
	end
endmodule : tb_top
